// [hdl/dlat_pkg.sv]
// constants and types shared by the dnp event throttle block
package dlat_pkg;
  // ===========================================================
  // event buffer
  localparam int EVT_CAP   = 100;
  localparam int ING_DEPTH = 32;
  localparam int EVT_DW    = 14;
  typedef struct packed {
    logic [1:0]        cls;
    logic [EVT_DW-1:0] data;
  } dlat_evt_t;
  localparam int EVT_W = $bits(dlat_evt_t);
  // ===========================================================
  // time base
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYC          = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_OVF_HOLD_MS = 10;
  // ===========================================================
  // settings and encodings
  localparam int N_CLS    = 3;
  localparam int N_SCALE  = 5;
  localparam int INT_SCALE = 100;
  localparam logic [1:0]  UNSOL_IMMEDIATE = 2'h1;
  localparam logic [15:0] LFSR_SEED       = 16'hace1;
  typedef struct packed {
    logic [15:0] delay_ms;
    logic [7:0]  count;
  } dlat_throttle_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_BACKOFF,
    ST_SEND,
    ST_DRAIN
  } dlat_state_t;
endpackage : dlat_pkg

// [hdl/dlat_top.sv]
// event buffer, send throttle, csma link access, counters and scaling
`timescale 1ns/1ps
`default_nettype none

// ===========================================================
// fifo with a random-access peek relative to the head
module dlat_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH),
  localparam int CW   = $clog2(DEPTH + 1)
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          in_valid_i,
  input  wire logic [W-1:0]  in_data_i,
  output logic               in_ready_o,
  output logic               out_valid_o,
  output logic [W-1:0]       out_data_o,
  input  wire logic          out_ready_i,
  input  wire logic [AW-1:0] peek_idx_i,
  output logic [W-1:0]       peek_data_o,
  output logic [CW-1:0]      count_o
);
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  logic          push;
  logic          pop;
  logic [AW:0]   pk_sum;
  logic [AW:0]   pk_adj;

  assign in_ready_o  = (cnt_ff != CW'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;
  assign pk_sum      = {1'b0, rd_ff} + {1'b0, peek_idx_i};
  assign pk_adj      = (pk_sum >= (AW+1)'(DEPTH)) ?
                       pk_sum - (AW+1)'(DEPTH) : pk_sum;
  assign peek_data_o = mem[pk_adj[AW-1:0]];
  assign count_o     = cnt_ff;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wrap_inc(wr_ff);
      if (pop)  rd_ff <= wrap_inc(rd_ff);
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end
endmodule : dlat_fifo

// ===========================================================
// top
// Contract
// [R01] Event store holds at most 100 events; further events are dropped as overflow.
// [R02] Unsolicited report per class when delay expires or count reached.
// [R03] Delay 0 with count 1 sends each class event immediately.
// [R04] Overflow indication is raised while the event store has overflowed.
// [R05] Internal path overflow also raises it and clears itself later.
// [R06] Master should run an integrity scan after the indication clears.
// [R07] Frozen counter per counter, same index, static only, no events.
// [R08] Collision detection is switchable; collision avoidance always runs.
// [R09] Wait busy link, back off when idle, resample, send if idle.
// [R10] Backoff equals silent interval plus random delay.
// [R11] Maximum random delay is slot width in ms times max slots.
// [R12] Random delay is whole slots 0..max, fresh random per backoff.
// [R13] With detection on, collision aborts at once and retries via avoidance.
// [R14] Scale index 0 uses fixed factor; 1..5 uses user factor.
// [R15] Deadband is judged on the fixed-scaled value regardless of presentation.
// [R16] Startup mode 1 starts unsolicited reporting without master permission.
module dlat_top import dlat_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYC,
  parameter int          N_CNT     = 8,
  localparam int CIW = $clog2(N_CNT)
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             evt_valid_i,
  input  wire dlat_evt_t        evt_i,
  output logic                  evt_ready_o,
  input  wire logic [1:0]       unsolicited_startup_mode_i,
  input  wire logic             unsol_enable_i,
  input  wire logic [15:0]      class1_event_delay_i,
  input  wire logic [7:0]       class1_event_count_i,
  input  wire logic [15:0]      class2_event_delay_i,
  input  wire logic [7:0]       class2_event_count_i,
  input  wire logic [15:0]      class3_event_delay_i,
  input  wire logic [7:0]       class3_event_count_i,
  input  wire logic             iin23_clear_i,
  output logic                  iin23_o,
  output logic [6:0]            evt_pending_o,
  input  wire logic             collision_detect_enable_i,
  input  wire logic [15:0]      silent_interval_setting_i,
  input  wire logic [7:0]       backoff_slot_width_i,
  input  wire logic [7:0]       backoff_max_slots_i,
  input  wire logic             link_busy_i,
  input  wire logic             collision_i,
  output logic                  tx_valid_o,
  output dlat_evt_t             tx_evt_o,
  output logic                  tx_last_o,
  input  wire logic             tx_ready_i,
  output logic                  tx_abort_o,
  output logic                  tx_active_o,
  input  wire logic [N_CNT-1:0] cnt_inc_i,
  input  wire logic             freeze_i,
  input  wire logic [CIW-1:0]   cnt_idx_i,
  output logic [15:0]           cnt_o,
  output logic [15:0]           frz_o,
  input  wire logic [15:0]      ana_value_i,
  input  wire logic [2:0]       scale_idx_i,
  input  wire logic [15:0]      user_scale_factor_1_i,
  input  wire logic [15:0]      user_scale_factor_2_i,
  input  wire logic [15:0]      user_scale_factor_3_i,
  input  wire logic [15:0]      user_scale_factor_4_i,
  input  wire logic [15:0]      user_scale_factor_5_i,
  input  wire logic [15:0]      deadband_i,
  output logic [15:0]           ana_scaled_o,
  output logic                  ana_evt_o
);
  // ===========================================================
  // time base and random source
  logic [16:0] ms_cnt_ff;
  logic        tick;
  logic [15:0] lfsr_ff;
  assign tick = (ms_cnt_ff == 17'(MS_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ms_cnt_ff <= '0;
      lfsr_ff   <= LFSR_SEED;
    end else begin
      ms_cnt_ff <= tick ? '0 : ms_cnt_ff + 1'b1;
      lfsr_ff   <= {lfsr_ff[14:0],
                    lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end

  // ===========================================================
  // internal path fifo feeding the event store
  dlat_state_t state_ff;
  localparam int SCW = $clog2(EVT_CAP + 1);
  localparam int SAW = $clog2(EVT_CAP);
  dlat_evt_t      ing_evt;
  dlat_evt_t      peek_evt;
  logic           ing_valid;
  logic           ing_ready;
  logic           st_in_ready;
  logic           st_pop;
  logic [SCW-1:0] st_count;
  logic [6:0]     idx_ff;
  logic           store_push;
  logic           store_drop;
  logic           ing_lost;

  // the store takes no writes while draining, so peek slots stay put
  assign ing_ready  = (state_ff != ST_DRAIN);
  assign store_push = ing_valid & ing_ready & st_in_ready;
  assign store_drop = ing_valid & ing_ready & ~st_in_ready; // [R01]
  assign st_pop     = (state_ff == ST_DRAIN) && (idx_ff != '0);

  dlat_fifo #(.W(EVT_W), .DEPTH(ING_DEPTH)) u_ing (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (evt_valid_i),
    .in_data_i   (evt_i),
    .in_ready_o  (evt_ready_o),
    .out_valid_o (ing_valid),
    .out_data_o  (ing_evt),
    .out_ready_i (ing_ready),
    .peek_idx_i  ('0),
    .peek_data_o (),
    .count_o     ()
  );

  dlat_fifo #(.W(EVT_W), .DEPTH(EVT_CAP)) u_store ( // [R01]
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (ing_valid & ing_ready),
    .in_data_i   (ing_evt),
    .in_ready_o  (st_in_ready),
    .out_valid_o (),
    .out_data_o  (),
    .out_ready_i (st_pop),
    .peek_idx_i  (idx_ff[SAW-1:0]),
    .peek_data_o (peek_evt),
    .count_o     (st_count)
  );

  // ===========================================================
  // overflow indication
  logic       buf_ovf_ff;
  logic [7:0] hold_ff;
  assign ing_lost = evt_valid_i & ~evt_ready_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_ovf_ff    <= 1'b0;
      hold_ff       <= '0;
      iin23_o       <= 1'b0;
      evt_pending_o <= '0;
    end else begin
      // a drop in the clearing cycle keeps the flag set
      buf_ovf_ff <= store_drop | (buf_ovf_ff & ~iin23_clear_i); // [R04]
      if (ing_lost) begin
        hold_ff <= 8'(INT_OVF_HOLD_MS); // [R05]
      end else if (tick && hold_ff != '0) begin
        hold_ff <= hold_ff - 1'b1; // [R05]
      end
      iin23_o       <= buf_ovf_ff | (hold_ff != '0); // [R04] [R05]
      evt_pending_o <= 7'(st_count);
    end
  end

  // ===========================================================
  // per-class send throttles
  dlat_throttle_t thr [N_CLS];
  logic [N_CLS-1:0] due;
  logic             snap;
  logic             unsol_on;
  assign thr[0] = '{class1_event_delay_i, class1_event_count_i};
  assign thr[1] = '{class2_event_delay_i, class2_event_count_i};
  assign thr[2] = '{class3_event_delay_i, class3_event_count_i};
  assign unsol_on = (unsolicited_startup_mode_i == UNSOL_IMMEDIATE) |
                    unsol_enable_i; // [R16]
  assign snap = (state_ff == ST_IDLE) && unsol_on && (|due) &&
                (st_count != '0); // [R02]

  for (genvar c = 0; c < N_CLS; c++) begin : g_cls
    logic [7:0]  pend_ff;
    logic [15:0] age_ff;
    logic        hit;
    assign hit = store_push && (ing_evt.cls == 2'(c + 1));
    // delay 0 or count 1 make a single pending event due at once
    assign due[c] = (pend_ff != '0) && ((age_ff >= thr[c].delay_ms) ||
                    (pend_ff >= thr[c].count)); // [R02] [R03]
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        pend_ff <= '0;
        age_ff  <= '0;
      end else if (snap) begin
        pend_ff <= 8'(hit);
        age_ff  <= '0;
      end else begin
        if (hit && pend_ff != 8'hff) pend_ff <= pend_ff + 1'b1;
        if (pend_ff == '0) begin
          age_ff <= '0;
        end else if (tick && age_ff != 16'hffff) begin
          age_ff <= age_ff + 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // link access: avoidance, detection, send and drain
  logic [16:0] rnd_prod;
  logic [7:0]  slots;
  logic [15:0] rnd_ms;
  logic [16:0] bo_load;
  logic [16:0] bo_ff;
  logic [6:0]  snap_n_ff;
  logic        coll_hit;
  assign rnd_prod = lfsr_ff[7:0] * ({1'b0, backoff_max_slots_i} + 9'h001);
  assign slots    = rnd_prod[15:8]; // [R12]
  assign rnd_ms   = slots * backoff_slot_width_i; // [R11]
  assign bo_load  = {1'b0, silent_interval_setting_i} + {1'b0, rnd_ms}; // [R10]
  assign coll_hit = collision_detect_enable_i & collision_i; // [R08] [R13]

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      bo_ff       <= '0;
      idx_ff      <= '0;
      snap_n_ff   <= '0;
      tx_valid_o  <= 1'b0;
      tx_evt_o    <= '0;
      tx_last_o   <= 1'b0;
      tx_abort_o  <= 1'b0;
      tx_active_o <= 1'b0;
    end else begin
      tx_abort_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (snap) begin
            snap_n_ff <= 7'(st_count);
            idx_ff    <= '0;
            state_ff  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!link_busy_i) begin
            bo_ff    <= bo_load; // [R09] [R12]
            state_ff <= ST_BACKOFF;
          end
        end
        ST_BACKOFF: begin
          if (bo_ff == '0) begin
            state_ff    <= link_busy_i ? ST_WAIT : ST_SEND; // [R09]
            tx_active_o <= ~link_busy_i;
          end else if (tick) begin
            bo_ff <= bo_ff - 1'b1;
          end
        end
        ST_SEND: begin
          if (coll_hit) begin
            // retry restarts the whole message from its first event
            tx_valid_o  <= 1'b0;
            tx_abort_o  <= 1'b1; // [R13]
            tx_active_o <= 1'b0;
            idx_ff      <= '0;
            state_ff    <= ST_WAIT; // [R13]
          end else if (!tx_valid_o) begin
            tx_valid_o <= 1'b1;
            tx_evt_o   <= peek_evt;
            tx_last_o  <= (idx_ff == snap_n_ff - 1'b1);
          end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            idx_ff     <= idx_ff + 1'b1;
            if (tx_last_o) begin
              tx_active_o <= 1'b0;
              state_ff    <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          if (idx_ff == '0) begin
            state_ff <= ST_IDLE;
          end else begin
            idx_ff <= idx_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // counters and frozen counters (static reads only, no events)
  logic [15:0] cnt_ff [N_CNT];
  logic [15:0] frz_ff [N_CNT];
  for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cnt_ff[i] <= '0;
        frz_ff[i] <= '0;
      end else begin
        cnt_ff[i] <= cnt_ff[i] + 16'(cnt_inc_i[i]);
        if (freeze_i) frz_ff[i] <= cnt_ff[i]; // [R07]
      end
    end
  end

  // ===========================================================
  // analogue scaling and deadband
  logic [15:0] factor;
  logic [31:0] prod;
  logic [31:0] quot;
  logic [15:0] last_ff;
  logic [15:0] diff;
  always_comb begin
    case (scale_idx_i) // [R14]
      3'h1:    factor = user_scale_factor_1_i;
      3'h2:    factor = user_scale_factor_2_i;
      3'h3:    factor = user_scale_factor_3_i;
      3'h4:    factor = user_scale_factor_4_i;
      3'h5:    factor = user_scale_factor_5_i;
      default: factor = 16'(INT_SCALE);
    endcase
  end
  // input already carries the fixed factor; rescale by factor/fixed
  assign prod = ana_value_i * factor;
  assign quot = prod / 32'(INT_SCALE);
  assign diff = (ana_value_i >= last_ff) ? ana_value_i - last_ff :
                last_ff - ana_value_i; // [R15]

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_o        <= '0;
      frz_o        <= '0;
      ana_scaled_o <= '0;
      ana_evt_o    <= 1'b0;
      last_ff      <= '0;
    end else begin
      cnt_o        <= cnt_ff[cnt_idx_i];
      frz_o        <= frz_ff[cnt_idx_i]; // [R07]
      ana_scaled_o <= (quot > 32'h0000ffff) ? 16'hffff : quot[15:0];
      ana_evt_o    <= (diff > deadband_i); // [R15]
      if (diff > deadband_i) last_ff <= ana_value_i;
    end
  end
endmodule : dlat_top

`default_nettype wire

// [tb/dlat_props.sv]
// checker for the dnp event throttle block
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// properties on the top ports
module dlat_props import dlat_pkg::*; (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        evt_valid_i,
  input wire logic        evt_ready_o,
  input wire logic        iin23_o,
  input wire logic [6:0]  evt_pending_o,
  input wire logic        collision_detect_enable_i,
  input wire logic        link_busy_i,
  input wire logic        collision_i,
  input wire logic        tx_valid_o,
  input wire dlat_evt_t   tx_evt_o,
  input wire logic        tx_ready_i,
  input wire logic        tx_abort_o,
  input wire logic        tx_active_o,
  input wire logic [15:0] ana_value_i,
  input wire logic [2:0]  scale_idx_i,
  input wire logic [15:0] ana_scaled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence lost_s; evt_valid_i && !evt_ready_o; endsequence
  sequence coll_s;
    collision_i && collision_detect_enable_i && tx_active_o;
  endsequence
  sequence abort_s; tx_abort_o ##1 !tx_valid_o; endsequence
  pend_cap_a: assert property (
    evt_pending_o <= 7'd100) else $error("store above capacity");
  path_ovf_a: assert property (
    lost_s |-> ##2 iin23_o) else $error("lost event not flagged");
  send_idle_a: assert property (
    $rose(tx_active_o) |-> $past(!link_busy_i)) else $error("sent on busy");
  valid_send_a: assert property (
    tx_valid_o |-> tx_active_o) else $error("valid outside send");
  hold_req_a: assert property (
    tx_valid_o && !tx_ready_i && !collision_i |=>
    tx_valid_o && $stable(tx_evt_o)) else $error("request not held");
  abort_now_a: assert property (
    coll_s |=> abort_s) else $error("collision not aborted");
  abort_cause_a: assert property (
    $rose(tx_abort_o) |-> $past(collision_i)) else $error("stray abort");
  abort_pulse_a: assert property (
    tx_abort_o |=> !tx_abort_o) else $error("abort too long");
  det_off_a: assert property (
    tx_abort_o |-> $past(collision_detect_enable_i))
    else $error("abort with detection off");
  scale_zero_a: assert property (
    scale_idx_i == 3'h0 |=> ana_scaled_o == $past(ana_value_i))
    else $error("fixed scaling wrong");
endmodule : dlat_props
bind dlat_top dlat_props u_dlat_props (.*);
`default_nettype wire

// [tb/dlat_link_model.sv]
// far side: master and other stations sharing the line
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// stall makes the master slow; collisions only hit a live frame
module dlat_link_model (
  input  wire logic tx_valid_i,
  input  wire logic busy_req_i,
  input  wire logic coll_req_i,
  input  wire logic stall_i,
  output logic      link_busy_o,
  output logic      collision_o,
  output logic      tx_ready_o
);
  assign link_busy_o = busy_req_i;
  assign collision_o = coll_req_i & tx_valid_i;
  assign tx_ready_o  = tx_valid_i & ~stall_i;
endmodule : dlat_link_model
`default_nettype wire

// [tb/dlat_top_test.sv]
// self-checking bench for the dnp event throttle block
`timescale 1ns/1ps
`default_nettype none
module dlat_top_test import dlat_pkg::*;;
  // ===========================================================
  // signals
  logic        clk_i, rst_n_i, evt_valid_i, evt_ready_o, unsol_enable_i;
  logic        iin23_clear_i, iin23_o, collision_detect_enable_i;
  logic        link_busy_i, collision_i, tx_valid_o, tx_last_o;
  logic        tx_ready_i, tx_abort_o, tx_active_o, freeze_i, ana_evt_o;
  logic        busy_req, coll_req, stall;
  logic [1:0]  unsolicited_startup_mode_i;
  logic [2:0]  cnt_idx_i, scale_idx_i;
  logic [6:0]  evt_pending_o;
  logic [7:0]  class1_event_count_i, class2_event_count_i;
  logic [7:0]  class3_event_count_i, cnt_inc_i;
  logic [7:0]  backoff_slot_width_i, backoff_max_slots_i;
  logic [15:0] class1_event_delay_i, class2_event_delay_i;
  logic [15:0] class3_event_delay_i, silent_interval_setting_i;
  logic [15:0] cnt_o, frz_o, ana_value_i, deadband_i, ana_scaled_o, lf;
  logic [15:0] user_scale_factor_1_i, user_scale_factor_2_i;
  logic [15:0] user_scale_factor_3_i, user_scale_factor_4_i;
  logic [15:0] user_scale_factor_5_i, uf[6], cm[8], fz[8];
  dlat_evt_t   evt_i, tx_evt_o;
  logic [16:0] exp_q[$];
  int          num_errors, check_count, cyc, n;
  assign user_scale_factor_1_i = uf[1];
  assign user_scale_factor_2_i = uf[2];
  assign user_scale_factor_3_i = uf[3];
  assign user_scale_factor_4_i = uf[4];
  assign user_scale_factor_5_i = uf[5];
  // short ms tick keeps the backoff to tens of cycles and the hold time to 100 cycles
  dlat_top #(.MS_CYCLES(10)) u_dlat_top (.*);
  dlat_link_model u_dlat_link_model (.tx_valid_i(tx_valid_o),
    .busy_req_i(busy_req), .coll_req_i(coll_req), .stall_i(stall),
    .link_busy_o(link_busy_i), .collision_o(collision_i),
    .tx_ready_o(tx_ready_i));
  // ===========================================================
  // helpers
  function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt_lfsr
  function automatic logic [15:0] sc(input logic [15:0] v, input int k);
    longint p;
    p = longint'(v) * (k > 5 ? 100 : uf[k]) / 100;
    return p > 65535 ? 16'hffff : p[15:0];
  endfunction : sc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [1:0] c, input bit last, input bit keep);
    @(negedge clk_i);
    lf = nxt_lfsr(lf);
    evt_valid_i = 1'b1;
    evt_i = {c, lf[13:0]};
    if (keep) exp_q.push_back({last, c, lf[13:0]});
  endtask : send
  task automatic wait_q(input int lim);
    @(negedge clk_i);
    evt_valid_i = 1'b0;
    for (n = 0; n < lim && (exp_q.size() != 0 || tx_active_o); n++)
      @(posedge clk_i);
    check(n < lim, 1);
    repeat (120) @(posedge clk_i);
  endtask : wait_q
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // ===========================================================
  // clock, monitor and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tx_valid_o && tx_ready_i)
      check({tx_last_o, tx_evt_o}, exp_q.size() ? exp_q.pop_front() : 'x);
    if (++cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  // ===========================================================
  // stimulus
  initial begin
    lf = 16'hb16b;
    rst_n_i = 1'b0;
    evt_valid_i = 1'b0;
    evt_i = '0;
    unsolicited_startup_mode_i = UNSOL_IMMEDIATE;
    unsol_enable_i = 1'b0;
    class1_event_delay_i = 16'h0;
    class1_event_count_i = 8'h1;
    class2_event_delay_i = 16'h03e8;
    class2_event_count_i = 8'h3;
    class3_event_delay_i = 16'h5;
    class3_event_count_i = 8'h32;
    iin23_clear_i = 1'b0;
    collision_detect_enable_i = 1'b0;
    silent_interval_setting_i = 16'h2;
    backoff_slot_width_i = 8'h1;
    backoff_max_slots_i = 8'h2;
    {busy_req, coll_req, stall, freeze_i} = 4'h0;
    {cnt_inc_i, cnt_idx_i, scale_idx_i} = '0;
    ana_value_i = 16'h0;
    deadband_i = 16'h5;
    cm = '{default: 16'h0};
    uf[0] = 16'h0064;
    for (int k = 1; k < 6; k++) uf[k] = 16'(k * 173);
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      lf = nxt_lfsr(lf);
      cnt_inc_i = lf[7:0];
      for (int k = 0; k < 8; k++) cm[k] += lf[k];
    end
    @(negedge clk_i);
    cnt_inc_i = 8'h0;
    freeze_i = 1'b1;
    @(negedge clk_i);
    freeze_i = 1'b0;
    fz = cm;
    cnt_inc_i = 8'hff;
    @(negedge clk_i);
    cnt_inc_i = 8'h0;
    for (int k = 0; k < 8; k++) begin
      cm[k] += 1;
      @(negedge clk_i);
      cnt_idx_i = 3'(k);
      @(negedge clk_i);
      check(cnt_o, cm[k]);
      check(frz_o, fz[k]);
    end
    $display("counters done");
    for (int k = 0; k < 7; k++) begin
      @(negedge clk_i);
      lf = nxt_lfsr(lf);
      scale_idx_i = 3'(k);
      ana_value_i = lf;
      @(negedge clk_i);
      check(ana_scaled_o, sc(lf, k));
    end
    scale_idx_i = 3'h3;
    ana_value_i = 16'h03e8;
    repeat (3) @(negedge clk_i);
    ana_value_i = 16'h03ed;
    @(negedge clk_i);
    check(ana_evt_o, 0);
    ana_value_i = 16'h03f7;
    @(negedge clk_i);
    check(ana_evt_o, 1);
    $display("scaling done");
    send(2'h1, 1, 1);
    @(negedge clk_i);
    evt_valid_i = 1'b0;
    for (n = 0; n < 200 && !tx_active_o; n++) @(posedge clk_i);
    check(n >= 13 && n <= 60, 1);
    wait_q(500);
    for (int i = 0; i < 3; i++) send(2'h2, i == 2, 1);
    wait_q(500);
    send(2'h3, 0, 1);
    send(2'h3, 1, 1);
    @(negedge clk_i);
    evt_valid_i = 1'b0;
    repeat (30) @(posedge clk_i);
    check(tx_active_o, 0);
    wait_q(500);
    $display("throttle done");
    collision_detect_enable_i = 1'b1;
    {busy_req, stall} = 2'b11;
    send(2'h1, 1, 1);
    @(negedge clk_i);
    evt_valid_i = 1'b0;
    repeat (60) @(posedge clk_i);
    check(tx_active_o, 0);
    @(negedge clk_i);
    busy_req = 1'b0;
    for (n = 0; n < 200 && !tx_valid_o; n++) @(posedge clk_i);
    @(negedge clk_i);
    coll_req = 1'b1;
    @(negedge clk_i);
    coll_req = 1'b0;
    check(tx_abort_o, 1);
    stall = 1'b0;
    // line busy again before the retry backoff ends: it must not send
    repeat (5) @(negedge clk_i);
    busy_req = 1'b1;
    for (n = 0; n < 80 && !tx_active_o; n++) @(posedge clk_i);
    check(n, 80);
    @(negedge clk_i);
    busy_req = 1'b0;
    wait_q(500);
    $display("link access done");
    {unsolicited_startup_mode_i, unsol_enable_i} = 3'h0;
    for (int i = 0; i < 140; i++) send(2'h1, i == 99, i < 100);
    @(negedge clk_i);
    evt_valid_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(evt_pending_o, 100);
    check(iin23_o, 1);
    @(negedge clk_i);
    iin23_clear_i = 1'b1;
    @(negedge clk_i);
    iin23_clear_i = 1'b0;
    @(negedge clk_i);
    check(iin23_o, 0);
    unsol_enable_i = 1'b1;
    for (n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge clk_i);
    check(n < 3000, 1);
    // store writes pause while the sent events are popped, so ingress fills
    for (int i = 0; i < 40; i++) send(2'h3, i == 31, i < 32);
    check(iin23_o, 1);
    check(evt_ready_o, 0);
    wait_q(3000);
    check(iin23_o, 0);
    $display("overflow done");
    final_report();
  end
endmodule : dlat_top_test
`default_nettype wire
